// file: ext_int_pkg.sv
// Package for the external interrupt latch: register map, fields, constants
package ext_int_pkg;

    // ****************************************************************
    // Register map (byte addresses on the APB bus)
    // ****************************************************************
    localparam logic [7:0] status_ctrl_offset = 8'h00; // ext_int_status_ctrl
    localparam logic [7:0] vector_offset      = 8'h04; // vector address pair

    // ****************************************************************
    // Field positions in ext_int_status_ctrl
    // ****************************************************************
    localparam int mode_bit    = 0;  // edge_level_select
    localparam int mask_bit    = 1;  // ext_int_mask
    localparam int ack_bit     = 2;  // latch_clear_strobe, write-only
    localparam int pending_bit = 3;  // ext_int_pending_flag, read-only
    localparam int pin_bit     = 4;  // synchronised pin level, read-only

    // ****************************************************************
    // Reset values and fixed vector addresses
    // ****************************************************************
    localparam logic mode_reset = 1'b0;  // Falling edge only
    localparam logic mask_reset = 1'b0;  // Requests enabled
    localparam logic [15:0] vector_addr_high = 16'hFFFA;
    localparam logic [15:0] vector_addr_low  = 16'hFFFB;

    // ****************************************************************
    // Types
    // ****************************************************************
    typedef enum logic [0:0] {
        edge_only      = 1'b0,
        edge_and_level = 1'b1
    } trigger_mode_e;

    // Sampled pin history: synchroniser stages and previous level
    typedef struct packed {
        logic stage1;
        logic stage2;
        logic prev;
    } pin_sample_s;

    // Request state: latch and synchronised pin level
    typedef struct packed {
        logic latch;
        logic level_low;
    } request_state_s;

endpackage : ext_int_pkg

// file: external_interrupt_latch.sv
// External interrupt latch with APB register access and vector fetch ack

module external_interrupt_latch (
    input  wire logic        i_clock,
    input  wire logic        i_nrst,
    input  wire logic        i_irq_n,
    input  wire logic        i_vector_ack,
    input  wire logic        i_psel,
    input  wire logic        i_penable,
    input  wire logic        i_pwrite,
    input  wire logic [7:0]  i_paddr,
    input  wire logic [31:0] i_pwdata,
    output logic      [31:0] o_prdata,
    output logic             o_pready,
    output logic             o_pslverr,
    output logic             o_irq_request,
    output logic             o_pin_level,
    output logic             o_pending
);

    // ****************************************************************
    // Pin synchroniser and edge detect
    // ****************************************************************
    ext_int_pkg::pin_sample_s    samp;
    ext_int_pkg::request_state_s req;
    ext_int_pkg::trigger_mode_e  mode;
    logic                        mask;
    logic                        next_latch;
    logic                        ack_seen;
    logic                        next_ack_seen;
    logic [31:0]                 next_prdata;

    // Two flops guard against metastability; prev only reads stage2
    always_ff @(posedge i_clock or negedge i_nrst) begin
        if (!i_nrst) begin
            samp <= '{stage1: 1'b1, stage2: 1'b1, prev: 1'b1};
        end else begin
            samp <= '{stage1: i_irq_n, stage2: samp.stage1,
                      prev: samp.stage2};
        end
    end

    wire pin_high     = samp.stage2;
    wire falling_edge = samp.prev & ~samp.stage2;
    wire level_hit    = (mode == ext_int_pkg::edge_and_level) & ~pin_high;

    // ****************************************************************
    // APB decode
    // ****************************************************************
    // Single-cycle access phase: pready is registered high in the cycle after each setup cycle
    wire access   = i_psel & i_penable;
    wire hit_sc   = (i_paddr == ext_int_pkg::status_ctrl_offset);
    wire hit_vec  = (i_paddr == ext_int_pkg::vector_offset);
    wire mapped   = hit_sc | hit_vec;
    wire wr_sc    = access & i_pwrite & hit_sc;
    wire sw_ack   = wr_sc & i_pwdata[ext_int_pkg::ack_bit];
    wire any_ack  = sw_ack | i_vector_ack;

    // ****************************************************************
    // Acknowledge memory for level mode
    // ****************************************************************
    // In level mode the pin may still be low when the ack comes, so the
    // ack is kept until the pin is high again; a new edge forgets it,
    // since that edge is a fresh request that needs its own ack
    wire ack_done = ack_seen & pin_high;
    assign next_ack_seen = next_latch & ~falling_edge
                         & (ack_seen | any_ack);

    // ****************************************************************
    // Latch update
    // ****************************************************************
    // Set wins over clear so an edge coincident with an ack is kept;
    // in level mode a low pin keeps the request alive after the ack
    assign next_latch = falling_edge | level_hit
                      | (req.latch & ~any_ack & ~ack_done);

    // Latch, mode and mask all return to defaults on reset
    always_ff @(posedge i_clock or negedge i_nrst) begin
        if (!i_nrst) begin
            req  <= '{latch: 1'b0, level_low: 1'b0};
            ack_seen <= 1'b0;
            mode <= ext_int_pkg::edge_only;
            mask <= ext_int_pkg::mask_reset;
        end else begin
            req.latch     <= next_latch;
            ack_seen      <= next_ack_seen;
            req.level_low <= ~pin_high;
            if (wr_sc) begin
                mode <= ext_int_pkg::trigger_mode_e'(
                        i_pwdata[ext_int_pkg::mode_bit]);
                mask <= i_pwdata[ext_int_pkg::mask_bit];
            end
        end
    end

    // ****************************************************************
    // Read data and outputs
    // ****************************************************************
    // Ack bit never stored, so it reads zero; pending ignores the mask
    always_comb begin
        next_prdata = 32'h0000_0000;
        if (hit_sc) begin
            next_prdata[ext_int_pkg::mode_bit]    = mode;
            next_prdata[ext_int_pkg::mask_bit]    = mask;
            next_prdata[ext_int_pkg::pending_bit] = next_latch;
            next_prdata[ext_int_pkg::pin_bit]     = pin_high;
        end else if (hit_vec) begin
            next_prdata = {ext_int_pkg::vector_addr_high,
                           ext_int_pkg::vector_addr_low};
        end
    end

    // Registered outputs; the CPU applies its own global mask on top
    always_ff @(posedge i_clock or negedge i_nrst) begin
        if (!i_nrst) begin
            o_prdata      <= 32'h0000_0000;
            o_pready      <= 1'b0;
            o_pslverr     <= 1'b0;
            o_irq_request <= 1'b0;
            o_pin_level   <= 1'b1;
            o_pending     <= 1'b0;
        end else begin
            o_pready      <= i_psel & ~i_penable;
            o_pslverr     <= i_psel & ~i_penable & ~mapped;
            o_prdata      <= (i_psel & ~i_penable) ? next_prdata
                                                   : 32'h0000_0000;
            o_irq_request <= next_latch & ~mask;
            o_pin_level   <= pin_high;
            o_pending     <= next_latch;
        end
    end

    // ****************************************************************
    // Assertions
    // ****************************************************************
    property p_edge_sets;
        @(posedge i_clock) disable iff (!i_nrst)
        falling_edge |=> o_pending;
    endproperty
    a_edge_sets: assert property (p_edge_sets)
        else $error("falling edge did not set pending");

    property p_ack_clears_edge;
        @(posedge i_clock) disable iff (!i_nrst)
        (req.latch && any_ack && !falling_edge && !level_hit)
        |=> !o_pending && !req.latch;
    endproperty
    a_ack_clears_edge: assert property (p_ack_clears_edge)
        else $error("acknowledge did not clear latch");

    property p_sw_ack;
        @(posedge i_clock) disable iff (!i_nrst)
        (sw_ack && mode == ext_int_pkg::edge_only && !falling_edge)
        |=> !req.latch;
    endproperty
    a_sw_ack: assert property (p_sw_ack)
        else $error("software acknowledge did not clear latch");

    property p_level_holds;
        @(posedge i_clock) disable iff (!i_nrst)
        (mode == ext_int_pkg::edge_and_level && !pin_high)
        |=> req.latch && o_pending;
    endproperty
    a_level_holds: assert property (p_level_holds)
        else $error("low level in level mode not pending");

    property p_edge_mode_hold;
        @(posedge i_clock) disable iff (!i_nrst)
        (req.latch && !any_ack && !ack_done) |=> req.latch;
    endproperty
    a_edge_mode_hold: assert property (p_edge_mode_hold)
        else $error("latch dropped without acknowledge");

    property p_mask_blocks;
        @(posedge i_clock) disable iff (!i_nrst)
        mask |=> !o_irq_request;
    endproperty
    a_mask_blocks: assert property (p_mask_blocks)
        else $error("request forwarded while masked");

    property p_pending_unmasked;
        @(posedge i_clock) disable iff (!i_nrst)
        (!mask && next_latch) |=> o_irq_request && o_pending;
    endproperty
    a_pending_unmasked: assert property (p_pending_unmasked)
        else $error("unmasked pending not forwarded");

    property p_ack_reads_zero;
        @(posedge i_clock) disable iff (!i_nrst)
        (i_psel && !i_penable && !i_pwrite && hit_sc)
        |=> !o_prdata[ext_int_pkg::ack_bit];
    endproperty
    a_ack_reads_zero: assert property (p_ack_reads_zero)
        else $error("ack bit read back nonzero");

    property p_pin_visible;
        @(posedge i_clock) disable iff (!i_nrst)
        $fell(samp.stage1) |=> ##1 !o_pin_level;
    endproperty
    a_pin_visible: assert property (p_pin_visible)
        else $error("pin level not reflected");

    property p_edge_detect;
        @(posedge i_clock) disable iff (!i_nrst)
        (pin_high ##1 !pin_high) |-> falling_edge;
    endproperty
    a_edge_detect: assert property (p_edge_detect)
        else $error("falling edge missed");

    property p_mask_rw;
        @(posedge i_clock) disable iff (!i_nrst)
        wr_sc |=> mask == $past(i_pwdata[ext_int_pkg::mask_bit]);
    endproperty
    a_mask_rw: assert property (p_mask_rw)
        else $error("mask write not stored");

    // Level mode: an earlier ack plus a high pin must end the request
    property p_level_release;
        @(posedge i_clock) disable iff (!i_nrst)
        (req.latch && ack_seen && pin_high && !falling_edge && !level_hit)
        |=> !req.latch;
    endproperty
    a_level_release: assert property (p_level_release)
        else $error("acked level request not released");

    // Reset is asynchronous, so state is cleared at any edge under reset
    property p_reset_state;
        @(posedge i_clock)
        !i_nrst |-> !req.latch && !o_pending && !o_irq_request
                    && mode == ext_int_pkg::edge_only && !mask;
    endproperty
    a_reset_state: assert property (p_reset_state)
        else $error("reset did not clear latch or mode");

    // An edge that follows an ack is a new request, not swallowed
    property p_edge_after_ack;
        @(posedge i_clock) disable iff (!i_nrst)
        (any_ack ##[1:20] falling_edge) |=> req.latch;
    endproperty
    a_edge_after_ack: assert property (p_edge_after_ack)
        else $error("edge after acknowledge not latched");

    // Edge-only mode never sets the latch from a steady level
    property p_edge_only_no_level;
        @(posedge i_clock) disable iff (!i_nrst)
        (mode == ext_int_pkg::edge_only && !req.latch && !falling_edge)
        |=> !req.latch;
    endproperty
    a_edge_only_no_level: assert property (p_edge_only_no_level)
        else $error("latch set without edge in edge mode");

    // Mode bit is stored by a status write
    property p_mode_rw;
        @(posedge i_clock) disable iff (!i_nrst)
        wr_sc |=> mode == $past(i_pwdata[ext_int_pkg::mode_bit]);
    endproperty
    a_mode_rw: assert property (p_mode_rw)
        else $error("mode write not stored");

    // Vector pair reads back as the two fixed addresses
    property p_vector_read;
        @(posedge i_clock) disable iff (!i_nrst)
        (i_psel && !i_penable && !i_pwrite && hit_vec)
        |=> o_prdata == {ext_int_pkg::vector_addr_high,
                         ext_int_pkg::vector_addr_low};
    endproperty
    a_vector_read: assert property (p_vector_read)
        else $error("vector pair read wrong");

    // Pending bit in read data agrees with the pending output
    property p_pending_read;
        @(posedge i_clock) disable iff (!i_nrst)
        (i_psel && !i_penable && !i_pwrite && hit_sc)
        |=> o_prdata[ext_int_pkg::pending_bit] == o_pending;
    endproperty
    a_pending_read: assert property (p_pending_read)
        else $error("pending bit read differs from flag");

    // Pin output and stored level are taken from the same sample
    property p_pin_level_tracks;
        @(posedge i_clock) disable iff (!i_nrst)
        o_pin_level != req.level_low;
    endproperty
    a_pin_level_tracks: assert property (p_pin_level_tracks)
        else $error("pin level output inconsistent");

    // A forwarded request always has a pending latch behind it
    property p_request_needs_pending;
        @(posedge i_clock) disable iff (!i_nrst)
        o_irq_request |-> o_pending;
    endproperty
    a_request_needs_pending: assert property (p_request_needs_pending)
        else $error("request forwarded without pending");

    // Zero wait states: every setup cycle is answered next cycle
    property p_pready_access;
        @(posedge i_clock) disable iff (!i_nrst)
        (i_psel && !i_penable) |=> o_pready;
    endproperty
    a_pready_access: assert property (p_pready_access)
        else $error("access phase not answered");

    // Unmapped addresses report an error and read zero
    property p_unmapped;
        @(posedge i_clock) disable iff (!i_nrst)
        (i_psel && !i_penable && !mapped)
        |=> o_pslverr && o_prdata == 32'h0000_0000;
    endproperty
    a_unmapped: assert property (p_unmapped)
        else $error("unmapped access not refused");

    c_edge_req:  cover property (@(posedge i_clock)
        falling_edge ##2 o_irq_request);
    c_sw_ack:    cover property (@(posedge i_clock)
        req.latch ##1 sw_ack ##1 !req.latch);
    c_level:     cover property (@(posedge i_clock)
        mode == ext_int_pkg::edge_and_level && any_ack && !pin_high);
    c_masked:    cover property (@(posedge i_clock) mask && o_pending);
    c_release:   cover property (@(posedge i_clock)
        ack_seen && pin_high ##1 !req.latch);

endmodule : external_interrupt_latch

// file: irq_source.sv
// Model of the external source that drives the active-low interrupt pin
module irq_source (
    input  wire logic i_clock,
    input  wire logic i_want_low,
    output logic      o_irq_n
);
    timeunit 1ns;
    timeprecision 1ns;

    // Released pin is pulled up, so it idles high rather than holding old data
    initial o_irq_n = 1'b1;

    // Pin moves just after a rising edge, as a synchronous source would
    always @(posedge i_clock) begin
        o_irq_n <= ~i_want_low;
    end
endmodule : irq_source

// file: testbench.sv
// Testbench for the external interrupt latch: APB tasks and pin scenarios
module testbench;
    timeunit 1ns;
    timeprecision 1ns;
    logic        clock, nrst, ack, psel, penable, pwrite, want_low, err;
    logic [7:0]  paddr;
    logic [31:0] pwdata, prdata, rd;
    logic        pready, pslverr, irq_req, pin_level, pending, irq_n;
    int          failures = 0;
    int          num_checks = 0;
    int          cycles = 0;

    external_interrupt_latch external_interrupt_latch_i (
        .i_clock(clock), .i_nrst(nrst), .i_irq_n(irq_n),
        .i_vector_ack(ack), .i_psel(psel), .i_penable(penable),
        .i_pwrite(pwrite), .i_paddr(paddr), .i_pwdata(pwdata),
        .o_prdata(prdata), .o_pready(pready), .o_pslverr(pslverr),
        .o_irq_request(irq_req), .o_pin_level(pin_level),
        .o_pending(pending));
    irq_source irq_source_i (.i_clock(clock), .i_want_low(want_low),
                             .o_irq_n(irq_n));

    // ************************************************************
    // Clock, timeout and closing report
    // ************************************************************
    initial begin
        clock = 1'b0;
        forever #50 clock = ~clock;
    end

    // A hang counts as a mismatch; the whole run needs under 1000 cycles
    always @(posedge clock) begin
        cycles <= cycles + 1;
        if (cycles == 5000) begin
            failures = failures + 1;
            report_and_stop();
        end
    end

    task automatic report_and_stop();
        $display("checks %0d mismatches %0d", num_checks, failures);
        if (failures == 0 && num_checks > 0) $display("Result: passed");
        else $display("Result: failed");
        $finish;
    endtask : report_and_stop

    // ************************************************************
    // Helper tasks
    // ************************************************************
    task automatic chk(input string name, input logic [31:0] exp,
                       input logic [31:0] got);
        num_checks++;
        if (got !== exp) begin
            failures++;
            $display("wrong value %s expected %h seen %h", name, exp, got);
        end
    endtask : chk

    task automatic tick(input int n);
        repeat (n) @(posedge clock);
    endtask : tick

    // One APB transfer; waits for pready rather than assuming zero waits
    task automatic apb(input logic wr, input logic [7:0] a,
                       input logic [31:0] wd);
        int n;
        n = 0;
        @(posedge clock);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= wr;
        paddr <= a;
        pwdata <= wd;
        @(posedge clock);
        penable <= 1'b1;
        do begin
            @(posedge clock);
            n++;
        end while (pready !== 1'b1 && n < 50);
        if (pready !== 1'b1) failures++;
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask : apb

    task automatic pin(input logic low);
        want_low <= low;
        tick(6);
    endtask : pin

    task automatic vec_ack();
        @(posedge clock);
        ack <= 1'b1;
        @(posedge clock);
        ack <= 1'b0;
        @(posedge clock);
    endtask : vec_ack

    // ************************************************************
    // Main sequence
    // ************************************************************
    initial begin
        {nrst, ack, psel, penable, pwrite, want_low} = 6'h00;
        paddr = 8'h00;
        pwdata = 32'h0000_0000;
        tick(16);
        nrst <= 1'b1;
        apb(1'b0, 8'h00, 32'h0000_0000);
        chk("status reset", 32'h0000_0010, rd);
        apb(1'b0, 8'h04, 32'h0000_0000);
        chk("vector pair", 32'hFFFA_FFFB, rd);
        apb(1'b0, 8'h08, 32'h0000_0000);
        chk("unmapped error", 32'h0000_0001, 32'(err));
        chk("unmapped read", 32'h0000_0000, rd);
        $display("test map done");
        // Edge mode: the latch must not re-arm while the pin stays low
        pin(1'b1);
        chk("pending edge", 32'h0000_0001, 32'(pending));
        chk("request edge", 32'h0000_0001, 32'(irq_req));
        chk("pin low", 32'h0000_0000, 32'(pin_level));
        vec_ack();
        chk("vector ack", 32'h0000_0000, 32'(pending));
        tick(3);
        chk("edge only", 32'h0000_0000, 32'(pending));
        pin(1'b0);
        chk("pin high", 32'h0000_0001, 32'(pin_level));
        $display("test edge mode done");
        apb(1'b1, 8'h00, 32'h0000_0002);
        pin(1'b1);
        chk("masked request", 32'h0000_0000, 32'(irq_req));
        chk("masked pending", 32'h0000_0001, 32'(pending));
        apb(1'b0, 8'h00, 32'h0000_0000);
        chk("status masked", 32'h0000_000A, rd);
        apb(1'b1, 8'h00, 32'h0000_0006);
        tick(2);
        chk("soft ack", 32'(pending), 32'h0000_0000);
        apb(1'b0, 8'h00, 32'h0000_0000);
        chk("ack reads 0", 32'h0000_0002, rd);
        pin(1'b0);
        pin(1'b1);
        chk("edge after ack", 32'(pending), 32'h0000_0001);
        apb(1'b1, 8'h00, 32'h0000_0000);
        tick(2);
        chk("unmasked", 32'(irq_req), 32'h0000_0001);
        apb(1'b1, 8'h00, 32'h0000_0004);
        pin(1'b0);
        $display("test mask done");
        // Level mode, acknowledge first, then pin high
        apb(1'b1, 8'h00, 32'h0000_0001);
        pin(1'b1);
        apb(1'b1, 8'h00, 32'h0000_0005);
        tick(2);
        chk("level held", 32'(pending), 32'h0000_0001);
        pin(1'b0);
        chk("level release", 32'(pending), 32'h0000_0000);
        // Level mode, pin high first, then acknowledge
        pin(1'b1);
        pin(1'b0);
        chk("wait for ack", 32'(pending), 32'h0000_0001);
        vec_ack();
        chk("level ack", 32'(pending), 32'h0000_0000);
        $display("test level mode done");
        // Reset with the pin low must drop the request at once
        pin(1'b1);
        nrst <= 1'b0;
        tick(2);
        chk("reset pending", 32'(pending), 32'h0000_0000);
        chk("reset request", 32'(irq_req), 32'h0000_0000);
        nrst <= 1'b1;
        apb(1'b0, 8'h00, 32'h0000_0000);
        chk("mode reset", 32'(rd[0]), 32'h0000_0000);
        pin(1'b0);
        $display("test reset done");
        report_and_stop();
    end
endmodule : testbench
